// file: logic/ledpol_mix.sv
// Purpose: Colour-mix duty generator for bi-colour indicator pairs
// Assumes: Eight-step share, one clock
// Notes: Reserved shares above full saturate at full
`timescale 1ns/1ps
module ledpol_mix
    import ledpol_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Shares
    input wire logic [MIX_W-1:0] share_even,
    input wire logic [MIX_W-1:0] share_odd,
    // Duty outputs
    output logic mix_even_on,
    output logic mix_odd_on
);
    logic [MIX_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic even_ff, nxt_even;
    logic odd_ff, nxt_odd;

    function automatic logic duty(input logic [MIX_W-1:0] share,
                                  input logic [MIX_CNT_W-1:0] cnt);
        logic [MIX_W-1:0] s;
        s = (share > MIX_FULL) ? MIX_FULL : share;
        return {1'b0, cnt} < s;
    endfunction

    always_comb begin
        nxt_cnt = cnt_ff + 3'h1;
        nxt_even = duty(share_even, cnt_ff);
        nxt_odd = duty(share_odd, cnt_ff);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            even_ff <= 1'b0;
            odd_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            even_ff <= nxt_even;
            odd_ff <= nxt_odd;
        end
    end

    assign mix_even_on = even_ff;
    assign mix_odd_on = odd_ff;
endmodule

// file: logic/ledpol_pkg.sv
// Purpose: Constants and carrier types for the indicator pin block
// Assumes: AHB-Lite register access, word data, one clock
// Notes: Register numbers are word indices; byte address is index times four
package ledpol_pkg;
    localparam logic [5:0] FUNC_IDX = 6'h10;
    localparam logic [5:0] POL_IDX = 6'h11;
    localparam logic [15:0] FUNC_RST = 16'h1777;
    localparam logic [15:0] POL_RST = 16'h8800;
    localparam int NPIN = 4;
    localparam int FN_W = 4;
    localparam int POL_W = 2;
    localparam int MIX_W = 4;
    localparam int MIX_EVEN_LSB = 8;
    localparam int MIX_ODD_LSB = 12;
    localparam int REG_W = 16;
    localparam int POL_FLOAT_BIT = 1;
    localparam int POL_HIGH_BIT = 0;
    localparam logic [3:0] FN_LINK = 4'h0;
    localparam logic [3:0] FN_LINK_ACT = 4'h1;
    localparam logic [3:0] FN_ALT2 = 4'h2;
    localparam logic [3:0] FN_ACT_ON = 4'h3;
    localparam logic [3:0] FN_ACT_BLINK = 4'h4;
    localparam logic [3:0] FN_ALT5 = 4'h5;
    localparam logic [3:0] FN_ALT6 = 4'h6;
    localparam logic [3:0] FN_ALT7 = 4'h7;
    localparam logic [3:0] FN_OFF = 4'h8;
    localparam logic [3:0] FN_ON = 4'h9;
    localparam logic [3:0] FN_HIZ = 4'hA;
    localparam logic [3:0] FN_BLINK = 4'hB;
    localparam logic [1:0] DUAL_PFX = 2'h3;
    localparam logic [1:0] DUAL_M1 = 2'h0;
    localparam logic [1:0] DUAL_M2 = 2'h1;
    localparam logic [1:0] DUAL_M3 = 2'h2;
    localparam logic [1:0] DUAL_M4 = 2'h3;
    localparam logic [1:0] POL_LO_HI = 2'h0;
    localparam logic [1:0] POL_HI_LO = 2'h1;
    localparam logic [1:0] POL_LO_Z = 2'h2;
    localparam logic [1:0] POL_HI_Z = 2'h3;
    localparam logic [3:0] MIX_FULL = 4'h8;
    localparam int MIX_CNT_W = 3;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam int GRP_W = 4;
    localparam logic [2:0] GRP_N_1000 = 3'h3;
    localparam logic [2:0] GRP_N_100 = 3'h2;
    localparam logic [2:0] GRP_N_10 = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic link;
        logic [1:0] speed;
        logic full_dup;
        logic master;
        logic act;
        logic tx;
        logic rx;
    } ledpol_status_t;

    typedef struct packed {
        logic on;
        logic hiz;
    } ledpol_drive_t;
endpackage

// file: logic/ledpol_top.sv
// Purpose: Indicator pin function, polarity and mix logic behind AHB-Lite
// Assumes: Status inputs synchronous to hclk; blink phase from a shared timer
// Notes: Pins follow status one cycle late
// Contract
// - Third pin code 0101 outputs recovered clock
// - Third pin field ignored when second dual
// - First pin field ignored when zeroth dual
// - Second pin: 0110 10/1000 link, 0111 10
// - Second pin codes 1100-1111 pair dual modes
// - Zeroth pin 0010 blinks speed group
// - Zeroth pin: 0000 link, 0111 gigabit link
// - First pin 0101 lit on 100 link
// - Third pin: 0111 duplex, 0110 10/gig master
// - Codes 0001, 0011, 0100 follow link activity
// - Forced on, high impedance, blink, off
// - Polarity 00 low-on, 01 high-on, both driven
// - Polarity 10/11 float when off
`timescale 1ns/1ps
module ledpol_top
    import ledpol_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Link status and timing
    input wire ledpol_status_t link_status,
    input wire logic blink_phase,
    input wire logic sync_rclk,
    input wire logic soft_reset,
    // Indicator pins
    output logic [NPIN-1:0] indicator_pin_o,
    output logic [NPIN-1:0] indicator_pin_oe_n
);
    logic [REG_W-1:0] func_ff, nxt_func;
    logic [REG_W-1:0] pol_ff, nxt_pol;
    logic dsel_ff, nxt_dsel;
    logic [5:0] didx_ff, nxt_didx;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff;
    logic [NPIN-1:0] pin_ff, nxt_pin;
    logic [NPIN-1:0] oe_n_ff, nxt_oe_n;
    logic [GRP_W-1:0] slot_ff, nxt_slot;
    logic blink_prev_ff;
    logic mix_even_on, mix_odd_on;
    logic grp_on;
    logic [2:0] grp_n;
    logic addr_rd;
    logic [5:0] addr_idx;

    function automatic logic [3:0] fn_of(input logic [REG_W-1:0] f, input int i);
        return f[FN_W*i +: FN_W];
    endfunction

    function automatic ledpol_drive_t pin_drive(input int idx, input logic [3:0] code,
                                                input ledpol_status_t st,
                                                input logic blink, input logic grp,
                                                input logic rclk);
        ledpol_drive_t d;
        d = '{on: 1'b0, hiz: 1'b0};
        unique case (code)
            FN_LINK_ACT: d.on = st.link & (~st.act | blink);
            FN_ACT_ON: d.on = st.act;
            FN_ACT_BLINK: d.on = st.act & blink;
            FN_OFF: d.on = 1'b0;
            FN_ON: d.on = 1'b1;
            FN_HIZ: d.hiz = 1'b1;
            FN_BLINK: d.on = blink;
            FN_LINK: d.on = (idx == 3) ? 1'b0 : st.link;
            FN_ALT2: begin
                if (idx == 0) begin
                    d.on = grp;
                end else if (idx == 2) begin
                    d.on = 1'b0;
                end else begin
                    d.on = st.link & (~st.rx | blink);
                end
            end
            FN_ALT5: begin
                if (idx == 1) begin
                    d.on = st.link & (st.speed == SPD_100);
                end else if (idx == 3) begin
                    d.on = rclk;
                end else begin
                    d.on = st.tx;
                end
            end
            FN_ALT6: begin
                unique case (idx)
                    0: d.on = st.link;
                    1: d.on = st.link & (st.speed == SPD_100);
                    2: d.on = st.link & (st.speed == SPD_10 | st.speed == SPD_1000);
                    default: d.on = st.link & (st.speed == SPD_10 |
                                  (st.speed == SPD_1000 & st.master));
                endcase
            end
            FN_ALT7: begin
                unique case (idx)
                    0: d.on = st.link & (st.speed == SPD_1000);
                    1: d.on = st.link & (st.speed == SPD_100);
                    2: d.on = st.link & (st.speed == SPD_10);
                    default: d.on = st.full_dup;
                endcase
            end
            default: d.on = 1'b0;
        endcase
        return d;
    endfunction

    function automatic ledpol_drive_t dual_drive(input logic [1:0] mode, input logic odd,
                                                 input ledpol_status_t st,
                                                 input logic blink, input logic mix_e,
                                                 input logic mix_o);
        ledpol_drive_t d;
        logic c;
        d = '{on: 1'b0, hiz: 1'b0};
        c = 1'b0;
        unique case (mode)
            DUAL_M1: c = st.link;
            DUAL_M2: c = st.link & (~st.act | blink);
            DUAL_M3: c = 1'b1;
            DUAL_M4: c = 1'b1;
        endcase
        if (mode == DUAL_M3) begin
            // Speed split across the pair, no mixing
            d.on = st.link & (odd ? (st.speed != SPD_1000) : (st.speed == SPD_1000));
        end else begin
            d.on = c & (odd ? mix_o : mix_e);
        end
        return d;
    endfunction

    // Returns {oe_n, level}
    function automatic logic [1:0] pin_level(input logic [1:0] pol, input ledpol_drive_t d);
        logic [1:0] r;
        r = 2'h0;
        if (d.hiz) begin
            r = 2'h2;
        end else if (d.on) begin
            r = {1'b0, pol[POL_HIGH_BIT]};
        end else if (pol[POL_FLOAT_BIT]) begin
            r = 2'h2;
        end else begin
            r = {1'b0, ~pol[POL_HIGH_BIT]};
        end
        return r;
    endfunction

    ledpol_mix u_mix (
        .hclk(hclk),
        .hresetn(hresetn),
        .share_even(pol_ff[MIX_EVEN_LSB +: MIX_W]),
        .share_odd(pol_ff[MIX_ODD_LSB +: MIX_W]),
        .mix_even_on(mix_even_on),
        .mix_odd_on(mix_odd_on)
    );

    // Register bus
    assign addr_idx = haddr[7:2];
    assign addr_rd = hsel & htrans[1] & hready & ~hwrite;

    always_comb begin
        nxt_dsel = hsel & htrans[1] & hready & hwrite & (hsize == HSIZE_WORD);
        nxt_didx = addr_idx;
        nxt_func = func_ff;
        nxt_pol = pol_ff;
        if (dsel_ff && didx_ff == FUNC_IDX) begin
            nxt_func = hwdata[REG_W-1:0];
        end
        if (dsel_ff && didx_ff == POL_IDX) begin
            nxt_pol = hwdata[REG_W-1:0];
        end
        nxt_rdata = 32'h0000_0000;
        if (addr_rd && haddr[1:0] == 2'h0 && addr_idx == FUNC_IDX) begin
            nxt_rdata = {16'h0000, nxt_func};
        end else if (addr_rd && haddr[1:0] == 2'h0 && addr_idx == POL_IDX) begin
            nxt_rdata = {16'h0000, nxt_pol};
        end
    end

    // Soft reset deliberately absent here so settings survive it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_ff <= FUNC_RST;
            pol_ff <= POL_RST;
            dsel_ff <= 1'b0;
            didx_ff <= '0;
            rdata_ff <= '0;
            ready_ff <= 1'b1;
        end else begin
            func_ff <= nxt_func;
            pol_ff <= nxt_pol;
            dsel_ff <= nxt_dsel;
            didx_ff <= nxt_didx;
            rdata_ff <= nxt_rdata;
            ready_ff <= 1'b1;
        end
    end

    // Speed blink group: sixteen blink phases per group
    always_comb begin
        grp_n = 3'h0;
        if (link_status.link) begin
            unique case (link_status.speed)
                SPD_1000: grp_n = GRP_N_1000;
                SPD_100: grp_n = GRP_N_100;
                SPD_10: grp_n = GRP_N_10;
                default: grp_n = 3'h0;
            endcase
        end
        grp_on = slot_ff[0] & (slot_ff[GRP_W-1:1] < grp_n);
        nxt_slot = slot_ff;
        if (soft_reset) begin
            nxt_slot = '0;
        end else if (blink_phase & ~blink_prev_ff) begin
            nxt_slot = slot_ff + 4'h1;
        end
    end

    // Pin drive
    always_comb begin
        ledpol_drive_t drv [NPIN];
        logic [1:0] lv;
        drv = '{default: '0};
        lv = 2'h0;
        for (int i = 0; i < NPIN; i++) begin
            drv[i] = pin_drive(i, fn_of(func_ff, i), link_status, blink_phase, grp_on,
                               sync_rclk);
        end
        for (int p = 0; p < NPIN; p += 2) begin
            if (fn_of(func_ff, p) >> 2 == 4'(DUAL_PFX)) begin
                // Odd partner's own field has no effect
                drv[p] = dual_drive(2'(fn_of(func_ff, p)), 1'b0, link_status, blink_phase,
                                    mix_even_on, mix_odd_on);
                drv[p+1] = dual_drive(2'(fn_of(func_ff, p)), 1'b1, link_status, blink_phase,
                                      mix_even_on, mix_odd_on);
            end
        end
        nxt_pin = '0;
        nxt_oe_n = '1;
        for (int i = 0; i < NPIN; i++) begin
            lv = pin_level(pol_ff[POL_W*i +: POL_W], drv[i]);
            nxt_oe_n[i] = lv[1];
            nxt_pin[i] = lv[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff <= '0;
            oe_n_ff <= '1;
            slot_ff <= '0;
            blink_prev_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            oe_n_ff <= nxt_oe_n;
            slot_ff <= nxt_slot;
            blink_prev_ff <= blink_phase;
        end
    end

    assign hreadyout = ready_ff;
    assign hrdata = rdata_ff;
    assign hresp = 1'b0;
    assign indicator_pin_o = pin_ff;
    assign indicator_pin_oe_n = oe_n_ff;

    property p_rclk;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[15:8] == {FN_ALT5, FN_ALT7} && pol_ff[7:6] == POL_HI_LO)
            |=> (indicator_pin_o[3] == $past(sync_rclk) && !indicator_pin_oe_n[3]);
    endproperty
    a_rclk: assert property (p_rclk) else $error("pin3 not recovered clock");

    property p_dual_hi;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[11:10] == DUAL_PFX && func_ff[15:12] == FN_HIZ && pol_ff[7:6] == POL_HI_LO)
            |=> !indicator_pin_oe_n[3];
    endproperty
    a_dual_hi: assert property (p_dual_hi) else $error("pin3 field not ignored");

    property p_dual_lo;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[3:2] == DUAL_PFX && func_ff[7:4] == FN_HIZ && pol_ff[3:2] == POL_HI_LO)
            |=> !indicator_pin_oe_n[1];
    endproperty
    a_dual_lo: assert property (p_dual_lo) else $error("pin1 field not ignored");

    property p_ten_only;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[11:8] == FN_ALT7 && pol_ff[5:4] == POL_HI_LO)
            |=> indicator_pin_o[2] == $past(link_status.link && link_status.speed == SPD_10);
    endproperty
    a_ten_only: assert property (p_ten_only) else $error("pin2 10M code wrong");

    property p_group_nolink;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[3:0] == FN_ALT2 && !link_status.link && pol_ff[1:0] == POL_HI_LO) [*2]
            |=> indicator_pin_o[0] == 1'b0;
    endproperty
    a_group_nolink: assert property (p_group_nolink) else $error("blink without link");

    property p_gig;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[3:0] == FN_ALT7 && pol_ff[1:0] == POL_HI_LO)
            |=> indicator_pin_o[0] == $past(link_status.link && link_status.speed == SPD_1000);
    endproperty
    a_gig: assert property (p_gig) else $error("pin0 gigabit code wrong");

    property p_hundred;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[7:0] == {FN_ALT5, FN_LINK} && pol_ff[3:2] == POL_HI_LO)
            |=> indicator_pin_o[1] == $past(link_status.link && link_status.speed == SPD_100);
    endproperty
    a_hundred: assert property (p_hundred) else $error("pin1 100M code wrong");

    property p_duplex;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[15:8] == {FN_ALT7, FN_LINK} && pol_ff[7:6] == POL_LO_HI)
            |=> indicator_pin_o[3] == !$past(link_status.full_dup);
    endproperty
    a_duplex: assert property (p_duplex) else $error("pin3 duplex wrong");

    property p_act;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[11:8] == FN_ACT_ON && pol_ff[5:4] == POL_HI_LO)
            |=> indicator_pin_o[2] == $past(link_status.act);
    endproperty
    a_act: assert property (p_act) else $error("activity code wrong");

    property p_float;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[11:8] == FN_OFF && pol_ff[5:4] == POL_HI_Z) |=> indicator_pin_oe_n[2];
    endproperty
    a_float: assert property (p_float) else $error("off not floating");

    property p_mix_zero;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[3:0] == {DUAL_PFX, DUAL_M4} && pol_ff[11:8] == 4'h0
         && pol_ff[1:0] == POL_HI_LO) [*3] |-> indicator_pin_o[0] == 1'b0;
    endproperty
    a_mix_zero: assert property (p_mix_zero) else $error("zero share lit");

    property p_keep;
        @(posedge hclk) disable iff (!hresetn)
        (soft_reset && !dsel_ff) |=> (func_ff == $past(func_ff) && pol_ff == $past(pol_ff));
    endproperty
    a_keep: assert property (p_keep) else $error("soft reset changed settings");

    property p_reserved;
        @(posedge hclk) disable iff (!hresetn)
        (func_ff[7:0] == 8'hC0 && pol_ff[3:2] == POL_LO_Z) |=> indicator_pin_oe_n[1];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code lit");
endmodule

// file: testbench/ledpol_led_model.sv
// Purpose: Board LED load seen on the indicator pins
// Assumes: Each pin pulled to the LED rail through the LED
// Notes: A floated pin reads 1, never a held old value
`timescale 1ns/1ps
module ledpol_led_model
    import ledpol_pkg::*;
(
    // Pins from the block
    input wire logic [NPIN-1:0] pin_o,
    input wire logic [NPIN-1:0] pin_oe_n,
    // Pad view
    output logic [NPIN-1:0] pad,
    output logic [NPIN-1:0] driven
);
    assign driven = ~pin_oe_n;
    // Weak pull wins only when undriven, so float never fakes a drive
    assign pad = pin_o | pin_oe_n;
endmodule

// file: testbench/phy_led_function_polarity_test.sv
// Purpose: Self-checking bench for the indicator pin block
// Assumes: Zero-wait AHB-Lite slave, steady status between checks
// Notes: Steady codes at random; blink group and mix timing directed
`timescale 1ns/1ps
module phy_led_function_polarity_test;
    import ledpol_pkg::*;
    localparam logic [31:0] A_FN = {24'h0, FUNC_IDX, 2'b00};
    localparam logic [31:0] A_PO = {24'h0, POL_IDX, 2'b00};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, blink, rclk, sres;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    ledpol_status_t st;
    logic [NPIN-1:0] po, poe_n, pad, drv;
    int failures, n_tests;
    int cyc = 0;
    int cnt [NPIN];
    int c1 [NPIN];

    ledpol_top i_dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .link_status(st), .blink_phase(blink), .sync_rclk(rclk), .soft_reset(sres),
        .indicator_pin_o(po), .indicator_pin_oe_n(poe_n));
    ledpol_led_model i_led(.pin_o(po), .pin_oe_n(poe_n), .pad(pad), .driven(drv));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic conclude();
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard well above the roughly fifteen hundred cycles the run needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; ready sampled at rising edges only
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [2:0] z, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= z;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Expected {driven, pad} for a steady code
    function automatic logic [1:0] exp_pad(input int p, input logic [3:0] f,
        input logic [1:0] pol, input ledpol_status_t s, input logic b, input logic r);
        logic on;
        logic g10;
        logic g100;
        logic g1k;
        g10 = s.link && s.speed == SPD_10;
        g100 = s.link && s.speed == SPD_100;
        g1k = s.link && s.speed == SPD_1000;
        case (f)
            FN_LINK: on = (p != 3) && s.link;
            FN_LINK_ACT: on = s.link && (!s.act || b);
            FN_ALT2: on = p[0] && s.link && (!s.rx || b);
            FN_ACT_ON: on = s.act;
            FN_ACT_BLINK: on = s.act && b;
            FN_ALT5: on = (p == 1) ? g100 : (p == 3) ? r : s.tx;
            FN_ALT6: on = (p == 0) ? s.link : (p == 1) ? g100 : (p == 2) ? g10 || g1k
                : g10 || (g1k && s.master);
            FN_ALT7: on = (p == 0) ? g1k : (p == 1) ? g100 : (p == 2) ? g10
                : s.full_dup;
            FN_ON: on = 1'b1;
            FN_BLINK: on = b;
            default: on = 1'b0;
        endcase
        if (f == FN_HIZ || (pol[1] && !on)) begin
            return 2'b01;
        end
        return {1'b1, pol[0] ? on : !on};
    endfunction

    task automatic count(output int c [NPIN]);
        c = '{default: 0};
        repeat (3) @(posedge hclk);
        repeat (16) begin
            @(negedge hclk);
            for (int p = 0; p < NPIN; p++) begin
                c[p] += (drv[p] === 1'b1 && pad[p] === 1'b1) ? 1 : 0;
            end
        end
        @(posedge hclk);
    endtask

    initial begin
        logic [15:0] fr, pr;
        logic [3:0] f [NPIN];
        int e;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = '0;
        st = '0;
        blink = 1'b0;
        rclk = 1'b0;
        sres = 1'b0;
        failures = 0;
        n_tests = 0;
        e = $urandom(7100);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, A_FN, '0, HSIZE_WORD, rd);
        chk(rd, {16'h0, FUNC_RST});
        ahb(1'b0, A_PO, '0, HSIZE_WORD, rd);
        chk(rd, {16'h0, POL_RST});
        chk(32'(hresp), 32'h0);
        ahb(1'b1, A_FN, 32'h1234, 3'h1, rd);
        ahb(1'b0, A_FN, '0, HSIZE_WORD, rd);
        chk(rd, {16'h0, FUNC_RST});
        ahb(1'b0, A_FN + 32'h8, '0, HSIZE_WORD, rd);
        chk(rd, 32'h0);
        // First twelve passes sweep codes 0000-1011 on all pins, except 0010 on pin 0
        for (int i = 0; i < 60; i++) begin
            for (int p = 0; p < NPIN; p++) begin
                f[p] = (i < 12) ? i[3:0] : 4'($urandom_range(p[0] ? 15 : 11));
                if (p == 0 && f[p] == FN_ALT2) begin
                    f[p] = FN_LINK;
                end
            end
            fr = {f[3], f[2], f[1], f[0]};
            pr = {8'h88, 8'($urandom)};
            ahb(1'b1, A_FN, {16'h0, fr}, HSIZE_WORD, rd);
            ahb(1'b1, A_PO, {16'h0, pr}, HSIZE_WORD, rd);
            e = $urandom;
            st <= {e[7], (e[6:5] == 2'h3) ? SPD_1000 : e[6:5], e[4:0]};
            blink <= e[8];
            rclk <= e[9];
            ahb(1'b0, A_FN, '0, HSIZE_WORD, rd);
            chk(rd, {16'h0, fr});
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            for (int p = 0; p < NPIN; p++) begin
                chk(32'(drv[p] * 2 + pad[p]), 32'(exp_pad(p, f[p], pr[2*p+:2], st, blink,
                    rclk)));
            end
            @(posedge hclk);
        end
        // Dual modes: odd field must not matter; mix kept at or below half
        st <= '0;
        blink <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            pr = {4'($urandom_range(4)), 4'($urandom_range(4)), 8'h55};
            ahb(1'b1, A_PO, {16'h0, pr}, HSIZE_WORD, rd);
            ahb(1'b1, A_FN, {16'h0, 4'h9, 4'hC + 4'(m), 4'h9, 4'hC + 4'(m)}, HSIZE_WORD, rd);
            count(c1);
            ahb(1'b1, A_FN, {16'h0, 4'hA, 4'hC + 4'(m), 4'hA, 4'hC + 4'(m)}, HSIZE_WORD, rd);
            count(cnt);
            chk(cnt[1], c1[1]);
            chk(cnt[3], c1[3]);
            if (m == 3) begin
                chk(cnt[0], 2 * pr[11:8]);
                chk(cnt[1], 2 * pr[15:12]);
            end
        end
        // Speed blink group: two whole groups per speed
        ahb(1'b1, A_PO, 32'h8801, HSIZE_WORD, rd);
        ahb(1'b1, A_FN, {16'h0, 16'h7772}, HSIZE_WORD, rd);
        for (int s = 0; s < 4; s++) begin
            st <= {s < 3, 2'(s), 5'h0};
            sres <= 1'b1;
            @(posedge hclk);
            sres <= 1'b0;
            e = 0;
            repeat (32) begin
                blink <= 1'b1;
                repeat (2) @(posedge hclk);
                @(negedge hclk);
                e += (pad[0] === 1'b1) ? 1 : 0;
                @(posedge hclk);
                blink <= 1'b0;
                repeat (2) @(posedge hclk);
            end
            chk(e, (s < 3) ? 2 * (s + 1) : 0);
        end
        ahb(1'b0, A_FN, '0, HSIZE_WORD, rd);
        chk(rd, 32'h7772);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, A_FN, '0, HSIZE_WORD, rd);
        chk(rd, {16'h0, FUNC_RST});
        ahb(1'b0, A_PO, '0, HSIZE_WORD, rd);
        chk(rd, {16'h0, POL_RST});
        conclude();
    end
endmodule
